// ==== tml_pkg.sv ====
/*
  Shared constants and types for the translation buffer maintenance logic.
  Assumes one core clock domain; special-register numbers are local.
*/
package tml_pkg;
  // ========================================
  // buffer geometry
  localparam int ENTRIES = 64;
  localparam int IDX_W = 6;
  localparam int EPN_W = 22;
  localparam int PAY_W = 43;
  // ========================================
  // special-register numbers
  localparam logic [9:0] SPR_SELECT = 10'h010;
  localparam logic [9:0] SPR_CONTEXT = 10'h011;
  localparam logic [9:0] SPR_PAGE_ATTR = 10'h012;
  localparam logic [9:0] SPR_REAL_PAGE = 10'h013;
  localparam logic [9:0] SPR_DEFAULTS = 10'h014;
  localparam logic [9:0] SPR_SEARCH = 10'h015;
  localparam logic [9:0] SPR_FAULT = 10'h016;
  localparam logic [9:0] SPR_CSR = 10'h017;
  // ========================================
  // field positions (lsb, little-endian numbering)
  localparam int M0_SEL = 28;
  localparam int M0_ENTRY_SELECT = 16;
  localparam int M0_NV = 0;
  localparam int M1_V = 31;
  localparam int M1_INVALIDATION_PROTECT = 30;
  localparam int M1_TID = 16;
  localparam int M1_TS = 12;
  localparam int M1_TSZ = 7;
  localparam int M2_EPN = 10;
  localparam int M2_VLE = 5;
  localparam int M2_WIMGE = 0;
  localparam int M3_RPN = 10;
  localparam int M3_USER = 6;
  localparam int M3_PERM = 0;
  localparam int M4_TIDSEL = 16;
  localparam int M6_SEARCH_PROCESS_ID = 16;
  localparam int M6_SAS = 0;
  localparam int CSR_FI = 1;
  localparam int EA_EPN = 10;
  localparam int EA_INVALL = 2;
  localparam int RB_EPN = 8;
  // ========================================
  // codes and reset values
  localparam logic [1:0] SEL_TLB1 = 2'h1;
  localparam logic [1:0] TIDSEL_PID0 = 2'h0;
  localparam logic [1:0] TIDSEL_ZERO = 2'h3;
  localparam logic [7:0] GLOBAL_TID = 8'h00;
  localparam logic [4:0] BOOT_TSIZE = 5'h02;
  localparam logic [3:0] BOOT_STORAGE_ATTRIBUTES = 4'h4;
  localparam logic [3:0] BOOT_USER = 4'h0;
  localparam logic [5:0] BOOT_PERM = 6'h3F;
  localparam int FLASH_CYCLES = 3;
  // ========================================
  // operations and sequencer states
  typedef enum logic [1:0] {
    TML_OP_READ = 2'h0,
    TML_OP_WRITE = 2'h1,
    TML_OP_SEARCH = 2'h2,
    TML_OP_INVAL = 2'h3
  } tml_op_t;
  typedef enum logic [1:0] {
    TML_ST_IDLE = 2'b01,
    TML_ST_FETCH = 2'b10
  } tml_state_t;
endpackage

// ==== tml_entry_store.sv ====
/*
  Payload store of the translation buffer: one write port, one read
  port with registered read data. Assumes the caller serialises access.
*/
`timescale 1ns/1ps
module tml_entry_store
  import tml_pkg::*;
#(
  parameter int W = PAY_W,
  parameter int DEPTH = ENTRIES,
  parameter int AW = IDX_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_q
);
  // ========================================
  // storage
  logic [W-1:0] mem_q [DEPTH];

  // write port, frozen while ce is low
  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data_q <= '0;
    end else if (ce && rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// ==== tml_match.sv ====
/*
  Associative compare over all entries with lowest-index priority.
  Purely combinational; assumes entry fields come from flip-flops.
*/
`timescale 1ns/1ps
module tml_match
  import tml_pkg::*;
#(
  parameter int N = ENTRIES,
  parameter int IW = IDX_W
) (
  input wire logic [EPN_W-1:0] effective_page_number,
  input wire logic as_bit,
  input wire logic [7:0] pid,
  input wire logic use_ctx,
  input wire logic [N-1:0] e_valid,
  input wire logic [N-1:0][EPN_W-1:0] e_epn,
  input wire logic [N-1:0] e_ts,
  input wire logic [N-1:0][7:0] e_tid,
  output logic [N-1:0] hit_vec,
  output logic hit_any,
  output logic [IW-1:0] hit_idx
);
  // ========================================
  // per-entry compare; context ignored for invalidation
  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign hit_vec[i] = e_valid[i] && (e_epn[i] == effective_page_number) && (!use_ctx ||
      ((e_ts[i] == as_bit) &&
      ((e_tid[i] == GLOBAL_TID) || (e_tid[i] == pid))));
  end

  // lowest matching index wins
  always_comb begin
    hit_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = IW'(i);
      end
    end
  end

  assign hit_any = |hit_vec;
endmodule

// ==== tml_maint.sv ====
/*
  Translation buffer maintenance: assist registers, entry read, write,
  search and invalidate, miss-time preload, boot entry, fault address,
  flash invalidate and bus-issue gating.
  Assumes the core pipeline drives all requests on core_clk; reset pins
  arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
// What this block does
// - entry read with select 01 copies the chosen entry to assist regs 1-3.
// - entry write with select 01 stores assist regs 1-3 into the chosen entry.
// - search matches page bits 0-21 plus search space and process id.
// - search hit loads assist regs 0-3 and sets valid; miss clears valid.
// - translation miss preloads assist regs 0-3 from defaults and faulting page.
// - translation miss copies next victim into entry select.
// - protected entries survive address invalidation, invalidate-all and flash.
// - reset invalidates every entry except entry 0.
// - boot entry is valid, space 0, global id, 4 KB size.
// - boot entry effective and real page come from the reset base pins.
// - boot entry has full permissions, user bits zero, cache inhibited, protected.
// - boot entry endian and encoding bits come from reset mode pins.
// - guarded cache-missing accesses wait until older exceptions are known.
// - cache-miss bus request only once all older instructions are clean.
// - fault address captures effective address of faulting data access.
// - fault address register is readable and writable by software.
// - writing 1 to control bit 30 starts flash; hardware clears it.
// - flash invalidation finishes in 3 cycles, then bit reads zero.
// - writing 0 during a flash leaves it running.
// - 64 fully associative entries, indices 0 to 63.
// - translation id 0 is global and matches every process id.
// - default id selector 00 takes process id, 11 forces zero.
// - address invalidation compares page number only, may hit many.
module tml_maint
  import tml_pkg::*;
#(
  parameter int N = ENTRIES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic spr_wr_en,
  input wire logic spr_rd_en,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata_q,
  output logic spr_rvalid_q,
  input wire logic op_valid,
  input wire tml_op_t op_code,
  input wire logic [31:0] op_ea,
  output logic busy_q,
  input wire logic miss_valid,
  input wire logic miss_as,
  input wire logic [31:0] miss_ea,
  input wire logic [7:0] pid0,
  input wire logic dfault_valid,
  input wire logic [31:0] dfault_ea,
  input wire logic lsu_miss_req,
  input wire logic older_clear,
  output logic bus_issue_q,
  input wire logic [29:0] rst_base_pin,
  input wire logic rst_endian_pin,
  input wire logic rst_vle_pin
);
  // ========================================
  // declarations
  logic [31:0] pin_m_q, pin_s_q;
  logic boot_q;
  logic [1:0] sel_q, d_sel_q, d_tidsel_q, fl_cnt_q;
  logic [IDX_W-1:0] entry_select_q, nv_q, idx_q;
  logic m1_v_q, m1_ip_q, m1_ts_q, m2_vle_q, d_vle_q, sas_q, fi_q;
  logic [7:0] m1_tid_q, search_process_id_q;
  logic [4:0] m1_tsz_q, m2_wimge_q, d_tsz_q, d_wimge_q;
  logic [EPN_W-1:0] m2_epn_q, m3_rpn_q;
  logic [3:0] m3_user_q;
  logic [5:0] m3_perm_q;
  logic [31:0] data_fault_address_q;
  tml_state_t state_q;
  logic fetch_hit_q;
  logic [N-1:0] ent_v_q, ent_ip_q, ent_ts_q, kill;
  logic [N-1:0][EPN_W-1:0] ent_epn_q;
  logic [N-1:0][7:0] ent_tid_q;
  logic [N-1:0] hit_vec;
  logic hit_any, go, sel_ok, rd_go, wr_go, sx_go, iv_go, f_st;
  logic fetch_start, flash_start, flash_done;
  logic [IDX_W-1:0] hit_idx;
  logic [7:0] miss_tid;
  logic [PAY_W-1:0] pay_rd, pay_wr, boot_pay;
  logic [4:0] p_tsz, p_wimge;
  logic p_vle;
  logic [EPN_W-1:0] p_rpn;
  logic [3:0] p_user;
  logic [5:0] p_perm;

  // ========================================
  // reset pin synchronisers
  always_ff @(posedge core_clk) begin
    if (ce) begin
      pin_m_q <= {rst_endian_pin, rst_vle_pin, rst_base_pin};
      pin_s_q <= pin_m_q;
    end
  end

  // one-cycle boot load after reset release
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      boot_q <= 1'b1;
    end else if (ce) begin
      boot_q <= 1'b0;
    end
  end

  // ========================================
  // decode
  assign sel_ok = (sel_q == SEL_TLB1);
  assign go = op_valid && !busy_q;
  assign rd_go = go && (op_code == TML_OP_READ) && sel_ok;
  assign wr_go = go && (op_code == TML_OP_WRITE) && sel_ok;
  assign sx_go = go && (op_code == TML_OP_SEARCH);
  assign iv_go = go && (op_code == TML_OP_INVAL);
  assign f_st = (state_q == TML_ST_FETCH);
  assign fetch_start = rd_go || (sx_go && hit_any);
  assign flash_start = spr_wr_en && (spr_num == SPR_CSR) &&
    spr_wdata[CSR_FI] && !fi_q;
  assign flash_done = fi_q && (fl_cnt_q == 2'h0);
  assign miss_tid = (d_tidsel_q == TIDSEL_PID0) ? pid0 : GLOBAL_TID;
  assign {p_tsz, p_vle, p_wimge, p_rpn, p_user, p_perm} = pay_rd;
  assign pay_wr = {m1_tsz_q, m2_vle_q, m2_wimge_q, m3_rpn_q, m3_user_q,
    m3_perm_q};
  assign boot_pay = {BOOT_TSIZE, pin_s_q[30], BOOT_STORAGE_ATTRIBUTES, pin_s_q[31],
    pin_s_q[29-:EPN_W], BOOT_USER, BOOT_PERM};

  // invalidation: page-only match or all, never protected entries
  assign kill = (iv_go ? (op_ea[EA_INVALL] ? '1 : hit_vec) :
    (flash_done ? '1 : '0)) & ~ent_ip_q;

  // ========================================
  // associative compare and payload store
  tml_match #(.N(N), .IW(IDX_W)) u_match (
    .effective_page_number(op_ea[31-:EPN_W]),
    .as_bit(sas_q),
    .pid(search_process_id_q),
    .use_ctx(op_code == TML_OP_SEARCH),
    .e_valid(ent_v_q),
    .e_epn(ent_epn_q),
    .e_ts(ent_ts_q),
    .e_tid(ent_tid_q),
    .hit_vec(hit_vec),
    .hit_any(hit_any),
    .hit_idx(hit_idx)
  );

  tml_entry_store #(.W(PAY_W), .DEPTH(N), .AW(IDX_W)) u_store (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .wr_en(boot_q || wr_go),
    .wr_addr(boot_q ? '0 : entry_select_q),
    .wr_data(boot_q ? boot_pay : pay_wr),
    .rd_en(fetch_start),
    .rd_addr(rd_go ? entry_select_q : hit_idx),
    .rd_data_q(pay_rd)
  );

  // ========================================
  // per-entry tag, valid and protect state
  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        ent_v_q[i] <= (i == 0);
        ent_ip_q[i] <= (i == 0);
        ent_ts_q[i] <= 1'b0;
        ent_tid_q[i] <= GLOBAL_TID;
        ent_epn_q[i] <= '0;
      end else if (ce) begin
        if (boot_q && i == 0) begin
          ent_epn_q[i] <= pin_s_q[29-:EPN_W];
        end
        if (wr_go && entry_select_q == IDX_W'(i)) begin
          ent_v_q[i] <= m1_v_q;
          ent_ip_q[i] <= m1_ip_q;
          ent_ts_q[i] <= m1_ts_q;
          ent_tid_q[i] <= m1_tid_q;
          ent_epn_q[i] <= m2_epn_q;
        end else if (kill[i]) begin
          ent_v_q[i] <= 1'b0;
        end
      end
    end
  end

  // ========================================
  // sequencer: payload read takes one extra cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= TML_ST_IDLE;
      idx_q <= '0;
      fetch_hit_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        TML_ST_IDLE: begin
          if (fetch_start) begin
            state_q <= TML_ST_FETCH;
            idx_q <= rd_go ? entry_select_q : hit_idx;
            fetch_hit_q <= !rd_go;
          end
        end
        TML_ST_FETCH: begin
          state_q <= TML_ST_IDLE;
        end
        default: begin
          state_q <= TML_ST_IDLE;
        end
      endcase
    end
  end

  // busy covers fetch and flash; set during reset until boot is done
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b1;
    end else if (ce) begin
      busy_q <= fetch_start || flash_start || (fi_q && fl_cnt_q != 2'h0);
    end
  end

  // ========================================
  // flash invalidate control bit and cycle count
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fi_q <= 1'b0;
      fl_cnt_q <= 2'h0;
    end else if (ce) begin
      if (flash_start) begin
        fi_q <= 1'b1;
        fl_cnt_q <= 2'(FLASH_CYCLES - 1);
      end else if (fi_q) begin
        if (fl_cnt_q == 2'h0) begin
          fi_q <= 1'b0;
        end else begin
          fl_cnt_q <= fl_cnt_q - 2'h1;
        end
      end
    end
  end

  // ========================================
  // select register: miss, search result, then software
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_q <= '0;
      entry_select_q <= '0;
      nv_q <= '0;
    end else if (ce) begin
      if (miss_valid || (sx_go && !hit_any)) begin
        sel_q <= d_sel_q;
        entry_select_q <= nv_q;
      end else if (f_st && fetch_hit_q) begin
        sel_q <= SEL_TLB1;
        entry_select_q <= idx_q;
      end else if (spr_wr_en && spr_num == SPR_SELECT) begin
        sel_q <= spr_wdata[M0_SEL+:2];
        entry_select_q <= spr_wdata[M0_ENTRY_SELECT+:IDX_W];
        nv_q <= spr_wdata[M0_NV+:IDX_W];
      end
    end
  end

  // context register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      m1_v_q <= 1'b0;
      m1_ip_q <= 1'b0;
      m1_tid_q <= '0;
      m1_ts_q <= 1'b0;
      m1_tsz_q <= '0;
    end else if (ce) begin
      if (miss_valid) begin
        m1_v_q <= 1'b1;
        m1_ip_q <= 1'b0;
        m1_tid_q <= miss_tid;
        m1_ts_q <= miss_as;
        m1_tsz_q <= d_tsz_q;
      end else if (f_st) begin
        m1_v_q <= fetch_hit_q || ent_v_q[idx_q];
        m1_ip_q <= ent_ip_q[idx_q];
        m1_tid_q <= ent_tid_q[idx_q];
        m1_ts_q <= ent_ts_q[idx_q];
        m1_tsz_q <= p_tsz;
      end else if (sx_go && !hit_any) begin
        m1_v_q <= 1'b0;
        m1_ip_q <= 1'b0;
        m1_tid_q <= search_process_id_q;
        m1_ts_q <= sas_q;
        m1_tsz_q <= d_tsz_q;
      end else if (spr_wr_en && spr_num == SPR_CONTEXT) begin
        m1_v_q <= spr_wdata[M1_V];
        m1_ip_q <= spr_wdata[M1_INVALIDATION_PROTECT];
        m1_tid_q <= spr_wdata[M1_TID+:8];
        m1_ts_q <= spr_wdata[M1_TS];
        m1_tsz_q <= spr_wdata[M1_TSZ+:5];
      end
    end
  end

  // page attribute register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      m2_epn_q <= '0;
      m2_vle_q <= 1'b0;
      m2_wimge_q <= '0;
    end else if (ce) begin
      if (miss_valid || (sx_go && !hit_any && !f_st)) begin
        m2_epn_q <= miss_valid ? miss_ea[31-:EPN_W] : op_ea[31-:EPN_W];
        m2_vle_q <= d_vle_q;
        m2_wimge_q <= d_wimge_q;
      end else if (f_st) begin
        m2_epn_q <= ent_epn_q[idx_q];
        m2_vle_q <= p_vle;
        m2_wimge_q <= p_wimge;
      end else if (spr_wr_en && spr_num == SPR_PAGE_ATTR) begin
        m2_epn_q <= spr_wdata[M2_EPN+:EPN_W];
        m2_vle_q <= spr_wdata[M2_VLE];
        m2_wimge_q <= spr_wdata[M2_WIMGE+:5];
      end
    end
  end

  // real page register, zeroed on miss so the handler must fill it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      m3_rpn_q <= '0;
      m3_user_q <= '0;
      m3_perm_q <= '0;
    end else if (ce) begin
      if (miss_valid || (sx_go && !hit_any && !f_st)) begin
        m3_rpn_q <= '0;
        m3_user_q <= '0;
        m3_perm_q <= '0;
      end else if (f_st) begin
        m3_rpn_q <= p_rpn;
        m3_user_q <= p_user;
        m3_perm_q <= p_perm;
      end else if (spr_wr_en && spr_num == SPR_REAL_PAGE) begin
        m3_rpn_q <= spr_wdata[M3_RPN+:EPN_W];
        m3_user_q <= spr_wdata[M3_USER+:4];
        m3_perm_q <= spr_wdata[M3_PERM+:6];
      end
    end
  end

  // defaults and search registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      d_sel_q <= '0;
      d_tidsel_q <= '0;
      d_tsz_q <= '0;
      d_vle_q <= 1'b0;
      d_wimge_q <= '0;
      search_process_id_q <= '0;
      sas_q <= 1'b0;
    end else if (ce) begin
      if (spr_wr_en && spr_num == SPR_DEFAULTS) begin
        d_sel_q <= spr_wdata[M0_SEL+:2];
        d_tidsel_q <= spr_wdata[M4_TIDSEL+:2];
        d_tsz_q <= spr_wdata[M1_TSZ+:5];
        d_vle_q <= spr_wdata[M2_VLE];
        d_wimge_q <= spr_wdata[M2_WIMGE+:5];
      end
      if (miss_valid) begin
        search_process_id_q <= pid0;
        sas_q <= miss_as;
      end else if (spr_wr_en && spr_num == SPR_SEARCH) begin
        search_process_id_q <= spr_wdata[M6_SEARCH_PROCESS_ID+:8];
        sas_q <= spr_wdata[M6_SAS];
      end
    end
  end

  // fault address: hardware capture beats a software write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_fault_address_q <= '0;
    end else if (ce) begin
      if (dfault_valid) begin
        data_fault_address_q <= dfault_ea;
      end else if (spr_wr_en && spr_num == SPR_FAULT) begin
        data_fault_address_q <= spr_wdata;
      end
    end
  end

  // bus request only once every older instruction is clean
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bus_issue_q <= 1'b0;
    end else if (ce) begin
      bus_issue_q <= lsu_miss_req && older_clear;
    end
  end

  // ========================================
  // register readback, unmapped numbers read zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      spr_rdata_q <= '0;
      spr_rvalid_q <= 1'b0;
    end else if (ce) begin
      spr_rvalid_q <= spr_rd_en;
      if (spr_rd_en) begin
        case (spr_num)
          SPR_SELECT: spr_rdata_q <= {2'h0, sel_q, 6'h0, entry_select_q, 10'h0,
            nv_q};
          SPR_CONTEXT: spr_rdata_q <= {m1_v_q, m1_ip_q, 6'h0, m1_tid_q,
            3'h0, m1_ts_q, m1_tsz_q, 7'h0};
          SPR_PAGE_ATTR: spr_rdata_q <= {m2_epn_q, 4'h0, m2_vle_q,
            m2_wimge_q};
          SPR_REAL_PAGE: spr_rdata_q <= {m3_rpn_q, m3_user_q, m3_perm_q};
          SPR_DEFAULTS: spr_rdata_q <= {2'h0, d_sel_q, 10'h0, d_tidsel_q,
            4'h0, d_tsz_q, 1'h0, d_vle_q, d_wimge_q};
          SPR_SEARCH: spr_rdata_q <= {8'h0, search_process_id_q, 15'h0, sas_q};
          SPR_FAULT: spr_rdata_q <= data_fault_address_q;
          SPR_CSR: spr_rdata_q <= {30'h0, fi_q, 1'h0};
          default: spr_rdata_q <= '0;
        endcase
      end
    end
  end

  // ========================================
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset || !ce);

  sequence s_flash_run;
    fi_q [*3] ##1 !fi_q;
  endsequence
  sequence s_hit_fetch;
    sx_go && hit_any && !miss_valid ##1 !miss_valid;
  endsequence

  property p_flash_len;
    $rose(fi_q) |-> s_flash_run;
  endproperty
  a_flash_len: assert property (p_flash_len)
    else $error("flash invalidate not three cycles");
  property p_flash_clear;
    flash_done |=> (ent_v_q & ~ent_ip_q) == '0;
  endproperty
  a_flash_clear: assert property (p_flash_clear)
    else $error("unprotected entry valid after flash");
  property p_flash_hold;
    fi_q && fl_cnt_q != 2'h0 |=> fi_q;
  endproperty
  a_flash_hold: assert property (p_flash_hold)
    else $error("flash ended early");
  property p_prot;
    ent_v_q[0] && ent_ip_q[0] && !(wr_go && entry_select_q == '0) |=> ent_v_q[0];
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected entry lost valid");
  property p_boot;
    boot_q |-> ent_v_q[N-1:1] == '0 && ent_v_q[0] && ent_ip_q[0];
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot entry state wrong");
  property p_boot_page;
    boot_q |=> ent_epn_q[0] == $past(pin_s_q[29-:EPN_W]);
  endproperty
  a_boot_page: assert property (p_boot_page)
    else $error("boot page not from reset base");
  property p_miss;
    miss_valid |=> entry_select_q == $past(nv_q) && m1_v_q && m3_perm_q == '0;
  endproperty
  a_miss: assert property (p_miss)
    else $error("miss preload wrong");
  property p_hit;
    s_hit_fetch |=> m1_v_q && entry_select_q == $past(hit_idx, 2);
  endproperty
  a_hit: assert property (p_hit)
    else $error("search hit not loaded");
  property p_sx_miss;
    sx_go && !hit_any && !miss_valid |=> !m1_v_q;
  endproperty
  a_sx_miss: assert property (p_sx_miss)
    else $error("search miss left valid set");
  property p_data_fault_address;
    dfault_valid |=> data_fault_address_q == $past(dfault_ea);
  endproperty
  a_data_fault_address: assert property (p_data_fault_address)
    else $error("fault address not captured");
  property p_bus;
    bus_issue_q |-> $past(older_clear) && $past(lsu_miss_req);
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus issued before older clean");
endmodule

// ==== tml_core_model.sv ====
/*
  Core pipeline model: raises older_clear two cycles after a cache miss.
  Assumes one core_clk domain and an active-high reset.
*/
`timescale 1ns/1ps
module tml_core_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic lsu_miss_req,
  output logic older_clear
);
  logic [1:0] age_q;
  // older work retires a while after the miss is raised
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      age_q <= 2'h0;
    end else if (!lsu_miss_req) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  assign older_clear = lsu_miss_req && (age_q >= 2'h2);
endmodule

// ==== tb_tml_maint.sv ====
/*
  Bench for tml_maint: SPR and op tasks, sequences with expected values.
  Assumes tml_pkg and tml_core_model are compiled first.
*/
`timescale 1ns/1ps
module tb_tml_maint;
  import tml_pkg::*;
  localparam logic [29:0] BASE = 30'h1234_5600;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0, rd = 1'b0, opv = 1'b0, mv = 1'b0, dv = 1'b0;
  logic lsu = 1'b0, mas = 1'b0, rvalid, busy, bus, clr;
  logic [9:0] num = 10'h000;
  logic [7:0] pid = 8'h5A;
  logic [31:0] wd = 32'h0, ea = 32'h0, mea = 32'h0, dea = 32'h0, rdata;
  tml_op_t opc = TML_OP_READ;
  int miscompares = 0, comparisons = 0, cyc = 0;
  // ========================================
  // design and core model
  tml_maint i_tml_maint (.core_clk(core_clk), .reset(reset), .ce(1'b1),
    .spr_wr_en(wr), .spr_rd_en(rd), .spr_num(num), .spr_wdata(wd),
    .spr_rdata_q(rdata), .spr_rvalid_q(rvalid), .op_valid(opv),
    .op_code(opc), .op_ea(ea), .busy_q(busy), .miss_valid(mv),
    .miss_as(mas), .miss_ea(mea), .pid0(pid), .dfault_valid(dv),
    .dfault_ea(dea), .lsu_miss_req(lsu), .older_clear(clr),
    .bus_issue_q(bus), .rst_base_pin(BASE), .rst_endian_pin(1'b1),
    .rst_vle_pin(1'b0));
  tml_core_model i_tml_core_model (.core_clk(core_clk), .reset(reset),
    .lsu_miss_req(lsu), .older_clear(clr));
  // ========================================
  // clock and hang guard
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end
  // ========================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic sw(input logic [9:0] n, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    num <= n;
    wd <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic sr(input logic [9:0] n, input logic [31:0] e);
    @(posedge core_clk);
    rd <= 1'b1;
    num <= n;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("spr", e, rdata);
  endtask
  task automatic op(input tml_op_t c, input logic [31:0] a);
    @(posedge core_clk);
    opv <= 1'b1;
    opc <= c;
    ea <= a;
    @(posedge core_clk);
    opv <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic miss();
    @(posedge core_clk);
    mv <= 1'b1;
    mas <= 1'b1;
    mea <= 32'hABCD_E400;
    @(posedge core_clk);
    mv <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ========================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    sw(SPR_SELECT, 32'h1000_0000);
    op(TML_OP_READ, 32'h0);
    sr(SPR_CONTEXT, 32'hC000_0100);
    sr(SPR_PAGE_ATTR, {BASE[29:8], 10'h009});
    sr(SPR_REAL_PAGE, {BASE[29:8], 10'h03F});
    sw(SPR_SELECT, 32'h1005_0000);
    sw(SPR_CONTEXT, 32'h8033_0000);
    op(TML_OP_WRITE, 32'h0);
    op(TML_OP_READ, 32'h0);
    sr(SPR_CONTEXT, 32'h8033_0000);
    sw(SPR_CSR, 32'h2);
    sw(SPR_CSR, 32'h0);
    repeat (4) @(posedge core_clk);
    op(TML_OP_READ, 32'h0);
    sr(SPR_CONTEXT, 32'h0033_0000);
    sw(SPR_SELECT, 32'h1000_0000);
    op(TML_OP_READ, 32'h0);
    sr(SPR_CONTEXT, 32'hC000_0100);
    sw(SPR_CSR, 32'h2);
    @(negedge core_clk);
    chk("busy", 32'h1, {31'h0, busy});
    sr(SPR_CSR, 32'h2);
    sr(SPR_CSR, 32'h0);
    chk("busy", 32'h0, {31'h0, busy});
    // search hit on the global boot entry, then a miss
    sw(SPR_DEFAULTS, 32'h1000_0000);
    sw(SPR_SEARCH, 32'h0077_0000);
    op(TML_OP_SEARCH, {BASE[29:8], 10'h0});
    sr(SPR_CONTEXT, 32'hC000_0100);
    op(TML_OP_SEARCH, 32'hFFFF_FC00);
    sr(SPR_CONTEXT, 32'h0077_0000);
    // translation miss preload with both selector codes
    sw(SPR_SELECT, 32'h1000_0007);
    miss();
    sr(SPR_SELECT, 32'h1007_0007);
    sr(SPR_CONTEXT, 32'h805A_1000);
    sr(SPR_PAGE_ATTR, 32'hABCD_E400);
    sw(SPR_DEFAULTS, 32'h1003_0000);
    miss();
    sr(SPR_CONTEXT, 32'h8000_1000);
    // address invalidate ignores context; invalidate-all spares entry 0
    sw(SPR_REAL_PAGE, 32'h1357_9C3F);
    sw(SPR_SEARCH, 32'h0077_0000);
    op(TML_OP_WRITE, 32'h0);
    op(TML_OP_INVAL, 32'hABCD_E400);
    op(TML_OP_READ, 32'h0);
    sr(SPR_CONTEXT, 32'h0000_1000);
    sr(SPR_REAL_PAGE, 32'h1357_9C3F);
    op(TML_OP_INVAL, 32'h0000_0004);
    sw(SPR_SELECT, 32'h1000_0000);
    op(TML_OP_READ, 32'h0);
    sr(SPR_CONTEXT, 32'hC000_0100);
    // fault address register
    sw(SPR_FAULT, 32'h1234_ABCD);
    sr(SPR_FAULT, 32'h1234_ABCD);
    @(posedge core_clk);
    dv <= 1'b1;
    dea <= 32'hCAFE_0010;
    @(posedge core_clk);
    dv <= 1'b0;
    sr(SPR_FAULT, 32'hCAFE_0010);
    // bus request waits for older instructions
    @(posedge core_clk);
    lsu <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("bus", 32'h0, {31'h0, bus});
    @(negedge core_clk);
    chk("bus", 32'h1, {31'h0, bus});
    results();
  end
endmodule
